// [hw/lsd_params.svh]
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH
`define LSD_CLK_HZ 10000000
`define LSD_FILTER_TAU_NS 500000
`define LSD_FILTER_CYC ((`LSD_FILTER_TAU_NS / 100) > 0 ? (`LSD_FILTER_TAU_NS / 100) : 1)
`define LSD_SETTLE_NS 100000
`define LSD_SETTLE_CYC (`LSD_SETTLE_NS / 100)
`define LSD_RING_WINDOW_NS 50000000
`define LSD_RING_WINDOW_CYC (`LSD_RING_WINDOW_NS / 100)
`define LSD_OFFHOOK_THR 16'h01d1
`define LSD_ONHOOK_THR 16'h0195
`define LSD_GNDKEY_TRIG 16'h0014
`define LSD_GNDKEY_REL 16'h000a
`define LSD_OVERTEMP_C 16'h0096
`define LSD_ADDR_CTRL 4'h0
`define LSD_ADDR_STATUS 4'h1
`define LSD_ADDR_IRQ 4'h2
`define LSD_ADDR_MASK 4'h3
`define LSD_IRQ_FLAG_BIT 0
`define LSD_IRQ_TRIP_BIT 1
`define LSD_IRQ_OFFHOOK_BIT 2
`endif

// [hw/lsd_pkg.sv]
package lsd_pkg;
  typedef enum logic [1:0] {
    LSD_OPEN = 2'b00,
    LSD_ACTIVE = 2'b01,
    LSD_RINGING = 2'b10,
    LSD_STANDBY = 2'b11
  } lsd_state_t;
  typedef enum logic [1:0] {
    LSD_DET_NONE = 2'b00,
    LSD_DET_GNDKEY = 2'b01,
    LSD_DET_LOOP = 2'b10,
    LSD_DET_TRIP = 2'b11
  } lsd_det_t;
endpackage : lsd_pkg

// [hw/lsd_link_if.sv]
interface lsd_link_if;
  logic state_select_a;
  logic state_select_b;
  logic flag_enable_n;
  logic detector_choice;
  logic detect_flag_n;
  modport device (
    input state_select_a,
    input state_select_b,
    input flag_enable_n,
    input detector_choice,
    output detect_flag_n
  );
  modport ctrl (
    output state_select_a,
    output state_select_b,
    output flag_enable_n,
    output detector_choice,
    input detect_flag_n
  );
endinterface : lsd_link_if

// [hw/lsd_device.sv]
`include "lsd_params.svh"
module lsd_device (
  input wire logic clk_sys,
  input wire logic rst_n,
  lsd_link_if.device link,
  input wire logic [15:0] loop_current,
  input wire logic [15:0] gndkey_diff,
  input wire logic [15:0] junction_temp,
  input wire logic trip_sense_in,
  input wire logic trip_reference_in,
  output logic tip_line_drive,
  output logic ring_line_drive,
  output logic line_hiz,
  output logic resistive_feed,
  output logic ring_relay_on
);
  logic [1:0] ctl_s1_reg, ctl_s2_reg, ctl_s1_next, ctl_s2_next;
  logic [1:0] trip_s1_reg, trip_s2_reg, trip_s1_next, trip_s2_next;
  logic loop_det_reg, loop_det_next;
  logic gk_det_reg, gk_det_next;
  logic hot_reg, hot_next;
  logic flag_n_reg, flag_n_next;
  logic tip_reg, ring_reg, hiz_reg, rfeed_reg, relay_reg;
  logic tip_next, ring_next, hiz_next, rfeed_next, relay_next;
  logic [1:0] en_s1_reg, en_s2_reg, en_s1_next, en_s2_next;
  lsd_pkg::lsd_state_t st;
  lsd_pkg::lsd_det_t sel;

  always_comb begin
    ctl_s1_next = {link.state_select_a, link.state_select_b};
    ctl_s2_next = ctl_s1_reg;
    en_s1_next = {link.flag_enable_n, link.detector_choice};
    en_s2_next = en_s1_reg;
    trip_s1_next = {trip_sense_in, trip_reference_in};
    trip_s2_next = trip_s1_reg;
    st = lsd_pkg::lsd_state_t'(ctl_s2_reg);
    hot_next = junction_temp > `LSD_OVERTEMP_C;
    loop_det_next = loop_det_reg;
    // Hysteresis keeps the flag from chattering near threshold
    if (loop_current > `LSD_OFFHOOK_THR) begin
      loop_det_next = 1'b1;
    end else if (loop_current < `LSD_ONHOOK_THR) begin
      loop_det_next = 1'b0;
    end
    gk_det_next = gk_det_reg;
    if (gndkey_diff > `LSD_GNDKEY_TRIG) begin
      gk_det_next = 1'b1;
    end else if (gndkey_diff < `LSD_GNDKEY_REL) begin
      gk_det_next = 1'b0;
    end
    sel = lsd_pkg::LSD_DET_NONE;
    unique case (st)
      lsd_pkg::LSD_OPEN: sel = lsd_pkg::LSD_DET_NONE;
      lsd_pkg::LSD_RINGING: sel = lsd_pkg::LSD_DET_TRIP;
      lsd_pkg::LSD_ACTIVE, lsd_pkg::LSD_STANDBY: begin
        sel = en_s2_reg[0] ? lsd_pkg::LSD_DET_LOOP : lsd_pkg::LSD_DET_GNDKEY;
      end
    endcase
    if (hot_reg) begin
      sel = lsd_pkg::LSD_DET_LOOP;
    end
    flag_n_next = 1'b1;
    if (!en_s2_reg[1]) begin
      unique case (sel)
        lsd_pkg::LSD_DET_NONE: flag_n_next = 1'b1;
        lsd_pkg::LSD_DET_GNDKEY: flag_n_next = ~gk_det_reg;
        lsd_pkg::LSD_DET_LOOP: flag_n_next = ~loop_det_reg;
        lsd_pkg::LSD_DET_TRIP: flag_n_next = trip_s2_reg[1] | ~trip_s2_reg[0];
      endcase
    end
    tip_next = (st == lsd_pkg::LSD_ACTIVE) && !hot_reg;
    ring_next = (st == lsd_pkg::LSD_ACTIVE) && !hot_reg;
    rfeed_next = (st == lsd_pkg::LSD_STANDBY) && !hot_reg;
    hiz_next = hot_reg || st != lsd_pkg::LSD_ACTIVE;
    relay_next = st == lsd_pkg::LSD_RINGING;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_s1_reg <= 2'h0;
      ctl_s2_reg <= 2'h0;
      en_s1_reg <= 2'h3;
      en_s2_reg <= 2'h3;
      trip_s1_reg <= 2'h2;
      trip_s2_reg <= 2'h2;
      loop_det_reg <= 1'b0;
      gk_det_reg <= 1'b0;
      hot_reg <= 1'b0;
      flag_n_reg <= 1'b1;
      tip_reg <= 1'b0;
      ring_reg <= 1'b0;
      hiz_reg <= 1'b1;
      rfeed_reg <= 1'b0;
      relay_reg <= 1'b0;
    end else begin
      ctl_s1_reg <= ctl_s1_next;
      ctl_s2_reg <= ctl_s2_next;
      en_s1_reg <= en_s1_next;
      en_s2_reg <= en_s2_next;
      trip_s1_reg <= trip_s1_next;
      trip_s2_reg <= trip_s2_next;
      loop_det_reg <= loop_det_next;
      gk_det_reg <= gk_det_next;
      hot_reg <= hot_next;
      flag_n_reg <= flag_n_next;
      tip_reg <= tip_next;
      ring_reg <= ring_next;
      hiz_reg <= hiz_next;
      rfeed_reg <= rfeed_next;
      relay_reg <= relay_next;
    end
  end

  assign link.detect_flag_n = flag_n_reg;
  assign tip_line_drive = tip_reg;
  assign ring_line_drive = ring_reg;
  assign line_hiz = hiz_reg;
  assign resistive_feed = rfeed_reg;
  assign ring_relay_on = relay_reg;
endmodule : lsd_device

// [hw/lsd_ctrl.sv]
// Chosen here: the address map and the plain strobed port.
`include "lsd_params.svh"
module lsd_ctrl #(
  parameter int FILTER_CYC = `LSD_FILTER_CYC,
  parameter int SETTLE_CYC = `LSD_SETTLE_CYC,
  parameter int RING_WINDOW_CYC = `LSD_RING_WINDOW_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  lsd_link_if.ctrl link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  output logic ring_relay_cmd
);
  logic [3:0] ctrl_reg, ctrl_next;
  logic [2:0] irq_reg, irq_next, mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_out_reg, irq_out_next;
  logic sync1_reg, sync2_reg;
  logic [31:0] filt_reg, filt_next, settle_reg, settle_next;
  logic [31:0] win_reg, win_next, low_reg, low_next;
  logic flag_reg, flag_next, offhook_reg, offhook_next;
  logic relay_reg, relay_next;
  logic valid;
  logic [2:0] ev;
  logic ctrl_wr, mask_wr, irq_rd, trip_seen;

  // Control word: [4] ring relay, [3:2] state selects, [1] flag enable low, [0] choice
  // Status word: [2] settled, [1] off-hook, [0] filtered flag, low when triggered
  // Event word: [0] flag moved, [1] ring trip, [2] off-hook began; a read clears it

  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] want);
    return a == want;
  endfunction : addr_is

  // Only a ringing line may have its relay dropped by a trip
  function automatic logic is_ringing(input logic [3:0] c);
    return c[3:2] == 2'b10;
  endfunction : is_ringing

  // The flag comes from another chip, so nothing reads it before the second flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= link.detect_flag_n;
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    ctrl_wr = wr && addr_is(addr, `LSD_ADDR_CTRL);
    mask_wr = wr && addr_is(addr, `LSD_ADDR_MASK);
    irq_rd = rd && addr_is(addr, `LSD_ADDR_IRQ);
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    if (ctrl_wr) begin
      ctrl_next = wdata[3:0];
    end
    if (mask_wr) begin
      mask_next = wdata[2:0];
    end
  end

  // Reset leaves the line in standby with the flag enabled and ground key chosen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 4'hc;
      mask_reg <= 3'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
    end
  end

  always_comb begin
    relay_next = relay_reg;
    if (ctrl_wr) begin
      relay_next = wdata[4];
    end
    // A trip drops the relay even if software rewrites it in the same cycle
    if (trip_seen) begin
      relay_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      relay_reg <= 1'b0;
    end else begin
      relay_reg <= relay_next;
    end
  end

  always_comb begin
    settle_next = settle_reg;
    if (settle_reg != 32'h0) begin
      settle_next = settle_reg - 32'h1;
    end
    // Any control write restarts the quiet time, since the flag may glitch on reselect
    if (ctrl_wr) begin
      settle_next = 32'(SETTLE_CYC);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= 32'h0;
    end else begin
      settle_reg <= settle_next;
    end
  end

  always_comb begin
    valid = settle_reg == 32'h0;
    filt_next = 32'h0;
    flag_next = flag_reg;
    // Digital filter stands in for the external capacitor, at the cost of delay
    if (valid && sync2_reg != flag_reg) begin
      filt_next = filt_reg + 32'h1;
      if (filt_reg + 32'h1 >= FILTER_CYC) begin
        flag_next = sync2_reg;
        filt_next = 32'h0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg <= 32'h0;
      flag_reg <= 1'b1;
    end else begin
      filt_reg <= filt_next;
      flag_reg <= flag_next;
    end
  end

  always_comb begin
    win_next = win_reg + 32'h1;
    low_next = low_reg + {31'h0, ~sync2_reg & valid};
    offhook_next = offhook_reg;
    // The raw flag toggles with the ring voltage, so only a low majority counts
    if (win_reg + 32'h1 >= RING_WINDOW_CYC) begin
      offhook_next = (low_reg << 1) > RING_WINDOW_CYC;
      win_next = 32'h0;
      low_next = 32'h0;
    end
    trip_seen = offhook_next && !offhook_reg && is_ringing(ctrl_reg);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_reg <= 32'h0;
      low_reg <= 32'h0;
      offhook_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
      low_reg <= low_next;
      offhook_reg <= offhook_next;
    end
  end

  always_comb begin
    ev = 3'h0;
    ev[`LSD_IRQ_FLAG_BIT] = flag_next != flag_reg;
    ev[`LSD_IRQ_TRIP_BIT] = trip_seen;
    ev[`LSD_IRQ_OFFHOOK_BIT] = offhook_next && !offhook_reg;
    irq_next = irq_reg | ev;
    if (irq_rd) begin
      irq_next = ev; // Set wins over read clear
    end
    irq_out_next = |(irq_next & mask_next);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 3'h0;
      irq_out_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
      irq_out_reg <= irq_out_next;
    end
  end

  always_comb begin
    rdata_next = 32'h0;
    if (rd) begin
      unique case (addr)
        `LSD_ADDR_CTRL: rdata_next = {27'h0, relay_reg, ctrl_reg};
        `LSD_ADDR_STATUS: rdata_next = {29'h0, valid, offhook_reg, flag_reg};
        `LSD_ADDR_IRQ: rdata_next = {29'h0, irq_reg};
        `LSD_ADDR_MASK: rdata_next = {29'h0, mask_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ctrl bits: [3]=state_select_a [2]=state_select_b [1]=flag_enable_n [0]=detector_choice
  assign link.state_select_a = ctrl_reg[3];
  assign link.state_select_b = ctrl_reg[2];
  assign link.flag_enable_n = ctrl_reg[1];
  assign link.detector_choice = ctrl_reg[0];
  assign rdata = rdata_reg;
  assign irq = irq_out_reg;
  assign ring_relay_cmd = relay_reg;
endmodule : lsd_ctrl

// [verif/lsd_link_chk.sv]
module lsd_link_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic state_select_a,
  input wire logic state_select_b,
  input wire logic flag_enable_n,
  input wire logic detector_choice,
  input wire logic detect_flag_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Flag lags the link levels by three edges, so causes are looked up three back
  property p_off_high;
    flag_enable_n [*4] |-> detect_flag_n;
  endproperty
  a_off_high: assert property (p_off_high) else $error("flag low while disabled");
  property p_open_high;
    (!state_select_a && !state_select_b) [*4] |-> detect_flag_n;
  endproperty
  a_open_high: assert property (p_open_high) else $error("flag low in open");
  property p_low_cause;
    !detect_flag_n |-> $past(!flag_enable_n && (state_select_a || state_select_b), 3);
  endproperty
  a_low_cause: assert property (p_low_cause) else $error("flag low with no source");
  property p_reset_standby;
    $rose(rst_n) |-> state_select_a && state_select_b && !flag_enable_n;
  endproperty
  a_reset_standby: assert property (p_reset_standby) else $error("not standby at reset");
  property p_off_stay;
    flag_enable_n [*4] |=> $stable(detect_flag_n);
  endproperty
  a_off_stay: assert property (p_off_stay) else $error("flag moved while disabled");
  property p_open_entry;
    $fell(state_select_a || state_select_b) ##1
      (!state_select_a && !state_select_b) [*3] |-> detect_flag_n;
  endproperty
  a_open_entry: assert property (p_open_entry) else $error("flag low entering open");
  c_gndkey: cover property (!detect_flag_n && !detector_choice);
endmodule : lsd_link_chk

// [verif/tb.sv]
`include "lsd_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic relay_cmd;
  logic [15:0] loop_i = 16'h0;
  logic [15:0] gk_i = 16'h0;
  logic [15:0] temp_i = 16'h0019;
  logic sense = 1'b1;
  logic refv = 1'b0;
  logic tip, ring, hiz, rfeed, relay;
  logic [63:0] note;
  logic [63:0] notes[$];
  int mismatches = 0;
  int checks = 0;
  int n;
  lsd_link_if link ();
  lsd_device u_lsd_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .loop_current(loop_i),
    .gndkey_diff(gk_i), .junction_temp(temp_i), .trip_sense_in(sense),
    .trip_reference_in(refv), .tip_line_drive(tip), .ring_line_drive(ring), .line_hiz(hiz),
    .resistive_feed(rfeed), .ring_relay_on(relay));
  // Short counts keep the ring window inside the run budget
  lsd_ctrl #(.FILTER_CYC(4), .SETTLE_CYC(3), .RING_WINDOW_CYC(40)) u_lsd_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(link), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .ring_relay_cmd(relay_cmd));
  lsd_link_chk u_lsd_link_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .state_select_a(link.state_select_a), .state_select_b(link.state_select_b),
    .flag_enable_n(link.flag_enable_n), .detector_choice(link.detector_choice),
    .detect_flag_n(link.detect_flag_n));
  always #50 clk_sys = ~clk_sys;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic cyc(int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [3:0] a, logic [31:0] m, logic [31:0] e);
    notes.push_back({m, e});
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask : rd_reg
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    rd_q <= rd;
    if (rd_q) begin
      note = notes.pop_front();
      chk("rdata", note[31:0], rdata & note[63:32]);
    end
  end
  function automatic logic [15:0] rt();
    return 16'($urandom_range(150));
  endfunction : rt
  task automatic row(logic [31:0] w, logic [15:0] l, logic [15:0] g, logic [15:0] t, logic e);
    wr_reg(`LSD_ADDR_CTRL, w);
    @(posedge clk_sys);
    loop_i <= l;
    gk_i <= g;
    temp_i <= t;
    cyc(8);
    chk("flag", {31'h0, e}, {31'h0, link.detect_flag_n});
  endtask : row
  initial begin
    void'($urandom(32'h9fe0));
    cyc(10);
    rst_n <= 1'b1;
    rd_reg(`LSD_ADDR_CTRL, 32'h1f, 32'h0c);
    $display("reset test done");
    row(32'h01, 16'h01d2, 16'h0, rt(), 1'b1);
    chk("hiz", 32'h1, {31'h0, hiz});
    row(32'h05, 16'h01d2, 16'h0, rt(), 1'b0);
    chk("hiz", 32'h0, {31'h0, hiz});
    chk("tip", 32'h1, {31'h0, tip});
    chk("ring", 32'h1, {31'h0, ring});
    row(32'h19, 16'h01d2, 16'h0, rt(), 1'b1);
    chk("hiz", 32'h1, {31'h0, hiz});
    chk("relay", 32'h1, {31'h0, relay});
    row(32'h0d, 16'h01d2, 16'h0, rt(), 1'b0);
    chk("feed", 32'h1, {31'h0, rfeed});
    chk("tip", 32'h0, {31'h0, tip});
    $display("mode test done");
    row(32'h05, 16'h0190, 16'h0, rt(), 1'b1);
    row(32'h05, 16'h01d1, 16'h0, rt(), 1'b1);
    row(32'h05, 16'h01d2, 16'h0, rt(), 1'b0);
    row(32'h05, 16'h0195, 16'h0, rt(), 1'b0);
    row(32'h05, 16'h0194, 16'h0, rt(), 1'b1);
    row(32'h04, 16'($urandom_range(900)), 16'h0014, rt(), 1'b1);
    row(32'h04, 16'($urandom_range(900)), 16'h0015, rt(), 1'b0);
    row(32'h04, 16'($urandom_range(900)), 16'h000a, rt(), 1'b0);
    row(32'h04, 16'($urandom_range(900)), 16'h0009, rt(), 1'b1);
    row(32'h07, 16'h01d2, 16'h0, rt(), 1'b1);
    $display("detector test done");
    row(32'h04, 16'h01d2, 16'h0, 16'h0097, 1'b0);
    chk("hiz", 32'h1, {31'h0, hiz});
    chk("ring", 32'h0, {31'h0, ring});
    row(32'h04, 16'h01d2, 16'h0, 16'h0096, 1'b1);
    chk("hiz", 32'h0, {31'h0, hiz});
    chk("tip", 32'h1, {31'h0, tip});
    $display("overtemp test done");
    wr_reg(`LSD_ADDR_MASK, 32'h7);
    rd_reg(`LSD_ADDR_MASK, 32'h7, 32'h7);
    rd_reg(4'hf, 32'hffffffff, 32'h0);
    row(32'h19, 16'h0, 16'h0, rt(), 1'b1);
    chk("relay_cmd", 32'h1, {31'h0, relay_cmd});
    rd_reg(`LSD_ADDR_IRQ, 32'h1, 32'h1);
    @(posedge clk_sys);
    sense <= 1'b0;
    refv <= 1'b1;
    // Off-hook must win the duty count, then the relay drops
    n = 0;
    while (relay_cmd !== 1'b0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      summarize();
    end
    chk("flag", 32'h0, {31'h0, link.detect_flag_n});
    chk("irq", 32'h1, {31'h0, irq});
    rd_reg(`LSD_ADDR_STATUS, 32'h2, 32'h2);
    rd_reg(`LSD_ADDR_IRQ, 32'h2, 32'h2);
    wr_reg(`LSD_ADDR_MASK, 32'h0);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    $display("ring trip test done");
    wr_reg(`LSD_ADDR_CTRL, 32'h05);
    rd_reg(`LSD_ADDR_STATUS, 32'h4, 32'h0);
    cyc(90);
    rd_reg(`LSD_ADDR_STATUS, 32'h7, 32'h5);
    $display("status test done");
    cyc(4);
    summarize();
  end
endmodule : tb
